/* File: design/irq_mask_pkg.sv */
// package for the peripheral interrupt enable mask register
package irq_mask_pkg;
	localparam logic [7:0] MASK_ADDR = 8'he6;
	localparam logic [7:0] MASK_RESET = 8'h00;
	// bits 3 and 1 are reserved: read zero, writes ignored
	localparam logic [7:0] MASK_WRITABLE = 8'hf5;
	localparam int SERIAL_BIT = 0;
	localparam int WINDOW_BIT = 2;
	localparam int CMP0_FALL_BIT = 4;
	localparam int CMP0_RISE_BIT = 5;
	localparam int CMP1_FALL_BIT = 6;
	localparam int CMP1_RISE_BIT = 7;

	typedef struct packed {
		logic cmp1_rise_flag;
		logic cmp1_fall_flag;
		logic cmp0_rise_flag;
		logic cmp0_fall_flag;
		logic rsvd3;
		logic window_flag;
		logic rsvd1;
		logic serial_flag;
	} irq_src_t;

	typedef struct packed {
		logic [7:0] mask;
		logic [7:0] rdata;
		logic [7:0] irq_out;
	} mask_state_t;
endpackage

/* File: design/peripheral_interrupt_enable_mask.sv */
// interrupt enable mask register gating peripheral requests to the core
`timescale 1ns/100ps

// Operation
// (RQ1) bit 7 set passes second comparator rising requests, clear blocks them
// (RQ2) bit 6 set passes second comparator falling requests, clear blocks them
// (RQ3) bit 5 set passes first comparator rising requests, clear blocks them
// (RQ4) bit 4 set passes first comparator falling requests, clear blocks them
// (RQ5) bit 2 set passes converter window requests, clear blocks them
// (RQ6) bit 0 set passes all serial interface requests, clear blocks them
module peripheral_interrupt_enable_mask
	import irq_mask_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// special function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// request sources and gated requests to the core
	input wire irq_src_t src,
	output irq_src_t irq_req,
	output logic [7:0] mask_out
);

	mask_state_t state_reg;
	mask_state_t state_next;
	logic [1:0] rst_sync_reg;
	logic rst_sync_n;
	logic mask_hit;
	wire [7:0] gated;

	// reset released through two flops, asserted at once
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end

	assign rst_sync_n = rst_sync_reg[1];
	assign mask_hit = (sfr_addr == MASK_ADDR);

	// RQ1 RQ2 RQ3 RQ4 RQ5 RQ6: per-source gating
	// reserved positions are zero in the mask, so never pass
	for (genvar i = 0; i < 8; i++) begin : g_gate
		assign gated[i] = src[i] & state_reg.mask[i];
	end

	always_comb begin
		state_next = state_reg;
		if (sfr_wr && mask_hit) begin
			state_next.mask = sfr_wdata & MASK_WRITABLE;
		end
		// unmapped reads return zero so other registers can share the bus
		if (sfr_rd && mask_hit) begin
			state_next.rdata = state_reg.mask;
		end else begin
			state_next.rdata = 8'h00;
		end
		// registered so the core never sees a gating glitch
		state_next.irq_out = gated;
	end

	always_ff @(posedge clock or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg.mask <= MASK_RESET;
			state_reg.rdata <= 8'h00;
			state_reg.irq_out <= 8'h00;
		end else begin
			state_reg <= state_next;
		end
	end

	assign sfr_rdata = state_reg.rdata;
	assign irq_req = state_reg.irq_out;
	assign mask_out = state_reg.mask;

	property p_cmp1_rise;
		@(posedge clock) disable iff (!rst_sync_n)
		irq_req.cmp1_rise_flag == ($past(src.cmp1_rise_flag)
			&& $past(state_reg.mask[CMP1_RISE_BIT]));
	endproperty
	a_cmp1_rise: assert property (p_cmp1_rise) // RQ1
		else $error("second comparator rising gate wrong");

	property p_cmp1_fall;
		@(posedge clock) disable iff (!rst_sync_n)
		!state_reg.mask[CMP1_FALL_BIT] |=> !irq_req.cmp1_fall_flag;
	endproperty
	a_cmp1_fall: assert property (p_cmp1_fall) // RQ2
		else $error("second comparator falling passed while masked");

	property p_cmp0_rise;
		@(posedge clock) disable iff (!rst_sync_n)
		(src.cmp0_rise_flag && state_reg.mask[CMP0_RISE_BIT])
			|=> irq_req.cmp0_rise_flag;
	endproperty
	a_cmp0_rise: assert property (p_cmp0_rise) // RQ3
		else $error("first comparator rising not passed");

	property p_cmp0_fall;
		@(posedge clock) disable iff (!rst_sync_n)
		irq_req.cmp0_fall_flag |-> $past(state_reg.mask[CMP0_FALL_BIT])
			&& $past(src.cmp0_fall_flag);
	endproperty
	a_cmp0_fall: assert property (p_cmp0_fall) // RQ4
		else $error("first comparator falling passed without cause");

	property p_window;
		@(posedge clock) disable iff (!rst_sync_n)
		(sfr_wr && sfr_addr == MASK_ADDR && !sfr_wdata[WINDOW_BIT])
			|-> ##2 !irq_req.window_flag;
	endproperty
	a_window: assert property (p_window) // RQ5
		else $error("window request passed after mask cleared");

	property p_serial;
		@(posedge clock) disable iff (!rst_sync_n)
		(sfr_wr && sfr_addr == MASK_ADDR) |=>
			mask_out[SERIAL_BIT] == $past(sfr_wdata[SERIAL_BIT]);
	endproperty
	a_serial: assert property (p_serial) // RQ6
		else $error("serial enable bit not stored");

	property p_reserved;
		@(posedge clock) disable iff (!rst_sync_n)
		!irq_req.rsvd3 && !irq_req.rsvd1 && !mask_out[3] && !mask_out[1];
	endproperty
	a_reserved: assert property (p_reserved) // reserved bits
		else $error("reserved bit nonzero");

	property p_readback;
		@(posedge clock) disable iff (!rst_sync_n)
		(sfr_rd && sfr_addr == MASK_ADDR) |=> sfr_rdata == $past(mask_out);
	endproperty
	a_readback: assert property (p_readback) // readback
		else $error("mask readback wrong");

	property p_cmp1_rise_block;
		@(posedge clock) disable iff (!rst_sync_n)
		!state_reg.mask[CMP1_RISE_BIT] |=> !irq_req.cmp1_rise_flag;
	endproperty
	a_cmp1_rise_block: assert property (p_cmp1_rise_block) // RQ1
		else $error("second comparator rising passed while masked");

	property p_cmp1_fall_pass;
		@(posedge clock) disable iff (!rst_sync_n)
		(src.cmp1_fall_flag && state_reg.mask[CMP1_FALL_BIT])
			|=> irq_req.cmp1_fall_flag;
	endproperty
	a_cmp1_fall_pass: assert property (p_cmp1_fall_pass) // RQ2
		else $error("second comparator falling not passed");

	property p_cmp0_rise_block;
		@(posedge clock) disable iff (!rst_sync_n)
		!state_reg.mask[CMP0_RISE_BIT] |=> !irq_req.cmp0_rise_flag;
	endproperty
	a_cmp0_rise_block: assert property (p_cmp0_rise_block) // RQ3
		else $error("first comparator rising passed while masked");

	property p_cmp0_fall_pass;
		@(posedge clock) disable iff (!rst_sync_n)
		(src.cmp0_fall_flag && state_reg.mask[CMP0_FALL_BIT])
			|=> irq_req.cmp0_fall_flag;
	endproperty
	a_cmp0_fall_pass: assert property (p_cmp0_fall_pass) // RQ4
		else $error("first comparator falling not passed");

	property p_cmp0_fall_block;
		@(posedge clock) disable iff (!rst_sync_n)
		!state_reg.mask[CMP0_FALL_BIT] |=> !irq_req.cmp0_fall_flag;
	endproperty
	a_cmp0_fall_block: assert property (p_cmp0_fall_block) // RQ4
		else $error("first comparator falling passed while masked");

	property p_window_pass;
		@(posedge clock) disable iff (!rst_sync_n)
		(src.window_flag && state_reg.mask[WINDOW_BIT])
			|=> irq_req.window_flag;
	endproperty
	a_window_pass: assert property (p_window_pass) // RQ5
		else $error("window request not passed");

	property p_window_gate;
		@(posedge clock) disable iff (!rst_sync_n)
		irq_req.window_flag == ($past(src.window_flag)
			&& $past(state_reg.mask[WINDOW_BIT]));
	endproperty
	a_window_gate: assert property (p_window_gate) // RQ5
		else $error("window gate wrong");

	property p_serial_block;
		@(posedge clock) disable iff (!rst_sync_n)
		!state_reg.mask[SERIAL_BIT] |=> !irq_req.serial_flag;
	endproperty
	a_serial_block: assert property (p_serial_block) // RQ6
		else $error("serial request passed while masked");

	property p_serial_gate;
		@(posedge clock) disable iff (!rst_sync_n)
		irq_req.serial_flag == ($past(src.serial_flag)
			&& $past(state_reg.mask[SERIAL_BIT]));
	endproperty
	a_serial_gate: assert property (p_serial_gate) // RQ6
		else $error("serial gate wrong");

	property p_rdata_zero;
		@(posedge clock) disable iff (!rst_sync_n)
		!(sfr_rd && sfr_addr == MASK_ADDR) |=> sfr_rdata == 8'h00;
	endproperty
	a_rdata_zero: assert property (p_rdata_zero) // readback
		else $error("read data not zero without a mask read");

	property p_mask_hold;
		@(posedge clock) disable iff (!rst_sync_n)
		!(sfr_wr && sfr_addr == MASK_ADDR) |=> $stable(mask_out);
	endproperty
	a_mask_hold: assert property (p_mask_hold) // register decode
		else $error("mask changed without a write");

	property p_mask_write;
		@(posedge clock) disable iff (!rst_sync_n)
		(sfr_wr && sfr_addr == MASK_ADDR) |=>
			mask_out == ($past(sfr_wdata) & MASK_WRITABLE);
	endproperty
	a_mask_write: assert property (p_mask_write) // register write
		else $error("mask write not stored");
endmodule

/* File: dv/irq_source_model.sv */
// peripheral request source model driving flag levels
`timescale 1ns/100ps
module irq_source_model
	import irq_mask_pkg::*;
(
	// flag levels requested by the bench
	input wire logic [7:0] level,
	// flags toward the mask
	output irq_src_t src
);
	// levels pass straight on; the bench moves them at the falling edge
	assign src = irq_src_t'(level);
endmodule

/* File: dv/peripheral_interrupt_enable_mask_bench.sv */
// self-checking bench for the interrupt enable mask
`timescale 1ns/100ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
	bad_count++; $display("Error %0t got %h exp %h", $time, a, e); end end
module peripheral_interrupt_enable_mask_bench;
	import irq_mask_pkg::*;
	logic clock = 0, rst_n = 0, wr = 0, rd = 0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, level = 8'h00, d, rdata, mask_out;
	logic [16:0] lfsr = 17'h1240b;
	irq_src_t src, irq;
	int bad_count = 0, checks_done = 0;
	always #2 clock = ~clock;
	irq_source_model u_src (.level(level), .src(src));
	peripheral_interrupt_enable_mask u_dut (.clock(clock), .rst_n(rst_n),
		.sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd), .sfr_wdata(wdata),
		.sfr_rdata(rdata), .src(src), .irq_req(irq), .mask_out(mask_out));
	function logic [16:0] step(input logic [16:0] x);
		return {x[15:0], x[16] ^ x[13]};
	endfunction
	function logic [7:0] gate(input logic [7:0] s, m);
		return s & m & MASK_WRITABLE;
	endfunction
	task wreg(input logic [7:0] a, v);
		@(negedge clock) begin addr = a; wdata = v; wr = 1; end
		@(negedge clock) wr = 0;
	endtask
	task rreg(input logic [7:0] a);
		@(negedge clock) begin addr = a; rd = 1; end
		@(negedge clock) rd = 0;
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge clock);
		rst_n = 1;
		repeat (4) @(negedge clock);
		`CHK(mask_out, MASK_RESET) // reset value
		for (int i = 0; i < 24; i++) begin
			lfsr = step(lfsr);
			d = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : lfsr[7:0];
			wreg(MASK_ADDR, d);
			`CHK(mask_out, gate(8'hff, d))
			// odd passes read an unmapped neighbour
			rreg(i[0] ? 8'he7 : MASK_ADDR);
			`CHK(rdata, i[0] ? 8'h00 : gate(8'hff, d)) // register readback
			level = (i < 2) ? 8'hff : lfsr[15:8];
			@(negedge clock);
			`CHK(irq, gate(level, d))
			$display("test %0d done", i);
		end
		// unmapped write leaves the mask alone
		wreg(8'he5, ~d);
		`CHK(mask_out, gate(8'hff, d)) // register decode
		$display("test unmapped done");
		// mid-run reset clears outputs at once, all sources requesting
		@(negedge clock) begin rst_n = 0; level = 8'hff; end
		#1;
		`CHK(mask_out, MASK_RESET) // reset value
		`CHK(rdata, 8'h00) // reset value
		`CHK(irq, 8'h00)
		repeat (5) @(negedge clock);
		rst_n = 1;
		repeat (4) @(negedge clock);
		`CHK(mask_out, MASK_RESET) // reset value
		`CHK(irq, 8'h00)
		$display("test reset done");
		results;
	end
	// whole run needs about 150 cycles
	initial begin
		#4000;
		bad_count++;
		results;
	end
endmodule
